// *** rtl/buck_ctrl_pkg.sv ***
// Shared constants and types for the dual buck controller
`default_nettype none
package buck_ctrl_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam logic [6:0] SLAVE_ADDR = 7'h68;
  localparam logic [7:0] REG_VOUT_ONE = 8'h00;
  localparam logic [7:0] REG_VOUT_TWO = 8'h01;
  localparam logic [7:0] REG_BUCK_OPT = 8'h05;
  localparam logic [7:0] REG_SYS_OPT = 8'h06;
  localparam logic [7:0] REG_STATUS = 8'h07;
  localparam logic [6:0] VOUT_RESET = 7'h10;
  localparam logic [7:0] BUCK_OPT_RESET = 8'h0C;
  localparam logic [7:0] SYS_OPT_RESET = 8'h00;
  localparam int OPT_SKIP_LSB = 0;
  localparam int OPT_BLEED_LSB = 2;
  localparam int OPT_SLEW_LSB = 4;
  localparam int SYS_PGDLY_LSB = 0;
  localparam int SYS_VSEL_BIT = 6;
  localparam logic [4:0] ZC_ENTRY_COUNT = 5'h10;
  localparam int PG_UNIT_US = 1000;
  localparam int PG_UNIT_CYCLES = PG_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int SLEW_BASE_NS = 1000;
  localparam int SLEW_BASE_CYCLES = SLEW_BASE_NS / CLK_NS;
  localparam int SOFT_START_NS = 256000;
  localparam int SOFT_START_CYCLES = (SOFT_START_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_W = 38;

  typedef enum logic [4:0] {
    CH_OFF = 5'b00001,
    CH_SOFT = 5'b00010,
    CH_PWM = 5'b00100,
    CH_SKIP_PULSE = 5'b01000,
    CH_SKIP_HOLD = 5'b10000
  } ch_state_t;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b001,
    I2C_RECV = 3'b010,
    I2C_SEND = 3'b100
  } i2c_state_t;
endpackage
`default_nettype wire

// *** rtl/reg_access_if.sv ***
// Register access path between the serial slave and the control core
`default_nettype none
interface reg_access_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rd_addr;
  logic [7:0] rdata;
  modport slave_side (output wr_en, output addr, output wdata, output rd_addr, input rdata);
  modport regs_side (input wr_en, input addr, input wdata, input rd_addr, output rdata);
endinterface
`default_nettype wire

// *** rtl/i2c_reg_slave.sv ***
// Serial two-wire slave that turns bus transfers into register accesses
`default_nettype none
module i2c_reg_slave
  import buck_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // Register side
  reg_access_if.slave_side regs
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  i2c_state_t st;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] ptr;
  logic [1:0] phase;
  logic is_read;
  logic ack_drive;
  logic data_drive;
  logic wr_en;
  logic [7:0] wdata;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  wire scl = scl_sync[1];
  wire sda = sda_sync[1];
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_seen = scl & scl_q & sda_q & ~sda;
  wire stop_seen = scl & scl_q & ~sda_q & sda;
  wire addr_match = (shreg[7:1] == SLAVE_ADDR);

  assign regs.wr_en = wr_en;
  assign regs.addr = ptr;
  assign regs.wdata = wdata;
  assign regs.rd_addr = ptr;
  // Open drain: only ever pulls low
  assign sda_oe = ack_drive | (data_drive & ~shreg[7]);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= I2C_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      phase <= 2'h0;
      is_read <= 1'b0;
      ack_drive <= 1'b0;
      data_drive <= 1'b0;
      wr_en <= 1'b0;
      wdata <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start_seen) begin
        st <= I2C_RECV;
        bit_cnt <= 4'h0;
        phase <= 2'h0;
        ack_drive <= 1'b0;
        data_drive <= 1'b0;
      end else if (stop_seen) begin
        st <= I2C_IDLE;
        ack_drive <= 1'b0;
        data_drive <= 1'b0;
      end else if (st != I2C_IDLE) begin
        if (scl_rise) begin
          if (bit_cnt < 4'h8) begin
            if (st == I2C_RECV) begin
              shreg <= {shreg[6:0], sda};
            end
            bit_cnt <= bit_cnt + 4'h1;
          end else begin
            bit_cnt <= 4'h9;
            if (st == I2C_SEND && sda) begin
              st <= I2C_IDLE;
            end
          end
        end else if (scl_fall) begin
          if (bit_cnt == 4'h8) begin
            data_drive <= 1'b0;
            if (st == I2C_RECV) begin
              if (phase == 2'h0) begin
                if (addr_match) begin
                  ack_drive <= 1'b1;
                  is_read <= shreg[0];
                  phase <= 2'h1;
                end else begin
                  st <= I2C_IDLE;
                end
              end else if (phase == 2'h1) begin
                ptr <= shreg;
                ack_drive <= 1'b1;
                phase <= 2'h2;
              end else begin
                wr_en <= 1'b1;
                wdata <= shreg;
                ack_drive <= 1'b1;
              end
            end
          end else if (bit_cnt == 4'h9) begin
            ack_drive <= 1'b0;
            bit_cnt <= 4'h0;
            if (is_read) begin
              // Auto-increment so a burst reads successive registers
              st <= I2C_SEND;
              shreg <= regs.rdata;
              ptr <= ptr + 8'h01;
              data_drive <= 1'b1;
            end
          end else if (st == I2C_SEND && bit_cnt != 4'h0) begin
            shreg <= {shreg[6:0], 1'b0};
          end
        end
        if (wr_en) begin
          ptr <= ptr + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/dual_buck_control_i2c.sv ***
// Dual buck converter digital control with serial register access
`default_nettype none
module dual_buck_control_i2c
  import buck_ctrl_pkg::*;
#(
  parameter int PG_DELAY_UNIT_CYCLES = PG_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Serial host bus
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  // Oscillator, enables, fused defaults
  input wire logic pwm_clk_in,
  input wire logic [1:0] buck_enable,
  input wire logic [6:0] fuse_code_one,
  input wire logic [6:0] fuse_code_two,
  // Per-channel analog comparators, bit 0 channel one
  input wire logic [1:0] zero_cross,
  input wire logic [1:0] peak_trip,
  input wire logic [1:0] ilim_reached,
  input wire logic [1:0] skip_trip,
  input wire logic [1:0] over_upper,
  input wire logic [1:0] at_nominal_low,
  input wire logic [1:0] under_lower,
  input wire logic [1:0] short_detect,
  input wire logic [1:0] dropout,
  input wire logic [1:0] pg_window,
  // Supply and thermal comparators
  input wire logic supply_above_rise,
  input wire logic supply_above_fall,
  input wire logic thermal_hot,
  input wire logic thermal_cool,
  // Channel drive and status
  output logic [1:0] high_side_on,
  output logic [1:0] osc_slow,
  output logic [1:0] bleed_on,
  output logic [1:0] channel_on,
  output logic [1:0] skip_active,
  output logic [1:0] soft_start_active,
  output logic [3:0] soft_ramp_one,
  output logic [3:0] soft_ramp_two,
  output logic [6:0] vout_code_one,
  output logic [6:0] vout_code_two,
  // Open-drain power-good pin
  output logic buck_power_good_out_o,
  output logic buck_power_good_out_oe
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] slew_cycles(input logic [1:0] sel);
    slew_cycles = 16'(SLEW_BASE_CYCLES << sel);
  endfunction

  function automatic logic [17:0] pg_delay(input logic [1:0] sel, input int unit);
    pg_delay = 18'((int'(sel) + 1) * unit);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Channel comparators, PWM clock, enables, fuses and supply_above_rise cross into the clock domain here
  wire [SYNC_W-1:0] async_in = {pwm_clk_in, buck_enable, fuse_code_one, fuse_code_two,
    zero_cross, peak_trip, ilim_reached, skip_trip, over_upper, at_nominal_low,
    under_lower, short_detect, dropout, pg_window, supply_above_rise};
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic pwm_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_a <= '0;
      sync_b <= '0;
      pwm_q <= 1'b0;
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
      pwm_q <= sync_b[37];
    end
  end

  wire pwm_s = sync_b[37];
  wire [1:0] en_s = sync_b[36:35];
  wire [6:0] fuse_one_s = sync_b[34:28];
  wire [6:0] fuse_two_s = sync_b[27:21];
  wire [1:0] zc_s = sync_b[20:19];
  wire [1:0] peak_s = sync_b[18:17];
  wire [1:0] ilim_s = sync_b[16:15];
  wire [1:0] skipt_s = sync_b[14:13];
  wire [1:0] upper_s = sync_b[12:11];
  wire [1:0] nominal_s = sync_b[10:9];
  wire [1:0] lower_s = sync_b[8:7];
  wire [1:0] short_s = sync_b[6:5];
  wire [1:0] dropout_s = sync_b[4:3];
  wire [1:0] window_s = sync_b[2:1];
  wire supply_rise_s = sync_b[0];
  wire pwm_tick = pwm_s & ~pwm_q;

  // Supply and thermal bits ride in a second short vector
  logic [3:0] misc_a;
  logic [3:0] misc_b;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      misc_a <= 4'h0;
      misc_b <= 4'h0;
    end else begin
      misc_a <= {supply_above_rise, supply_above_fall, thermal_hot, thermal_cool};
      misc_b <= misc_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg_access_if rif ();
  logic [6:0] vout_reg [2];
  logic [7:0] buck_option_reg;
  logic [7:0] system_option_reg;
  logic uv_lock;
  logic hot_shut;
  logic pg_state;

  i2c_reg_slave u_slave (
    .clock(clock),
    .sys_rst(sys_rst),
    .scl_in(serial_clock_pin),
    .sda_in(serial_data_pin_in),
    .sda_oe(serial_data_pin_oe),
    .regs(rif.slave_side)
  );
  assign serial_data_pin_out = 1'b0;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vout_reg[0] <= VOUT_RESET;
      vout_reg[1] <= VOUT_RESET;
      buck_option_reg <= BUCK_OPT_RESET;
      system_option_reg <= SYS_OPT_RESET;
    end else if (rif.wr_en) begin
      case (rif.addr)
        REG_VOUT_ONE: vout_reg[0] <= rif.wdata[6:0];
        REG_VOUT_TWO: vout_reg[1] <= rif.wdata[6:0];
        REG_BUCK_OPT: buck_option_reg <= rif.wdata;
        REG_SYS_OPT: system_option_reg <= rif.wdata;
        default: ;
      endcase
    end
  end

  wire [7:0] status_word = {2'h0, hot_shut, uv_lock, pg_state, skip_active[1],
    skip_active[0], channel_on[0] | channel_on[1]};
  assign rif.rdata = (rif.rd_addr == REG_VOUT_ONE) ? {1'b0, vout_reg[0]} :
                     (rif.rd_addr == REG_VOUT_TWO) ? {1'b0, vout_reg[1]} :
                     (rif.rd_addr == REG_BUCK_OPT) ? buck_option_reg :
                     (rif.rd_addr == REG_SYS_OPT) ? system_option_reg :
                     (rif.rd_addr == REG_STATUS) ? status_word : 8'h00;

  wire [1:0] skip_allow = buck_option_reg[OPT_SKIP_LSB +: 2];
  wire [1:0] bleed_allow = buck_option_reg[OPT_BLEED_LSB +: 2];
  wire [1:0] slew_sel = buck_option_reg[OPT_SLEW_LSB +: 2];
  wire [1:0] pg_sel = system_option_reg[SYS_PGDLY_LSB +: 2];
  wire vsel = system_option_reg[SYS_VSEL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Supply lockout and thermal shutdown; setting wins over release
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      uv_lock <= 1'b1;
      hot_shut <= 1'b0;
    end else begin
      if (!misc_b[2]) begin
        uv_lock <= 1'b1;
      end else if (misc_b[3] & supply_rise_s) begin
        uv_lock <= 1'b0;
      end
      if (misc_b[1]) begin
        hot_shut <= 1'b1;
      end else if (misc_b[0]) begin
        hot_shut <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output code slew toward the selected target
  logic [15:0] slew_cnt;
  wire slew_tick = (slew_cnt >= slew_cycles(slew_sel) - 16'h1);
  wire [6:0] target [2];
  logic [6:0] cur_code [2];
  assign target[0] = vsel ? vout_reg[0] : fuse_one_s;
  assign target[1] = vsel ? vout_reg[1] : fuse_two_s;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slew_cnt <= 16'h0;
    end else begin
      slew_cnt <= slew_tick ? 16'h0 : slew_cnt + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel state machines
  logic [11:0] soft_cnt [2];
  for (genvar c = 0; c < 2; c++) begin : g_ch
    ch_state_t st;
    ch_state_t next_st;
    logic [4:0] zc_cnt;
    logic zc_seen;
    logic hs;
    logic next_hs;
    wire run = en_s[c] & ~uv_lock & ~hot_shut;
    wire zc_cycle = zc_seen | zc_s[c];
    wire [4:0] next_zc = !zc_cycle ? 5'h0 : (zc_cnt == ZC_ENTRY_COUNT) ? zc_cnt : zc_cnt + 5'h1;
    wire soft_done = (soft_cnt[c] >= 12'(SOFT_START_CYCLES - 1));
    wire skip_entry = skip_allow[c] & pwm_tick & (next_zc == ZC_ENTRY_COUNT);

    always_comb begin
      next_st = st;
      case (st)
        CH_OFF: next_st = run ? CH_SOFT : CH_OFF;
        CH_SOFT: next_st = !run ? CH_OFF : (soft_done ? CH_PWM : CH_SOFT);
        CH_PWM: next_st = !run ? CH_OFF : (skip_entry ? CH_SKIP_PULSE : CH_PWM);
        CH_SKIP_PULSE: begin
          if (!run) begin
            next_st = CH_OFF;
          end else if (lower_s[c] || !skip_allow[c]) begin
            next_st = CH_PWM;
          end else if (upper_s[c]) begin
            next_st = CH_SKIP_HOLD;
          end
        end
        CH_SKIP_HOLD: begin
          if (!run) begin
            next_st = CH_OFF;
          end else if (lower_s[c] || !skip_allow[c]) begin
            next_st = CH_PWM;
          end else if (nominal_s[c]) begin
            next_st = CH_SKIP_PULSE;
          end
        end
        default: next_st = CH_OFF;
      endcase
    end

    always_comb begin
      next_hs = hs;
      if (st == CH_PWM || st == CH_SOFT) begin
        if (pwm_tick) begin
          next_hs = 1'b1;
        end
        if (peak_s[c]) begin
          next_hs = 1'b0;
        end
        if (dropout_s[c]) begin
          next_hs = 1'b1;
        end
      end else if (st == CH_SKIP_PULSE) begin
        if (pwm_tick) begin
          next_hs = 1'b1;
        end
        if (skipt_s[c]) begin
          next_hs = 1'b0;
        end
      end
      if (ilim_s[c]) begin
        next_hs = 1'b0;
      end
      if (next_st == CH_OFF || next_st == CH_SKIP_HOLD) begin
        next_hs = 1'b0;
      end
    end

    always_ff @(posedge clock) begin
      if (sys_rst) begin
        st <= CH_OFF;
        hs <= 1'b0;
      end else begin
        st <= next_st;
        hs <= next_hs;
      end
    end

    // Crossing seen any time in the cycle counts, judged at the edge
    always_ff @(posedge clock) begin
      if (sys_rst || st != CH_PWM) begin
        zc_seen <= 1'b0;
        zc_cnt <= 5'h0;
      end else if (pwm_tick) begin
        zc_seen <= 1'b0;
        zc_cnt <= next_zc;
      end else begin
        zc_seen <= zc_cycle;
      end
    end

    always_ff @(posedge clock) begin
      if (sys_rst || st != CH_SOFT) begin
        soft_cnt[c] <= 12'h0;
      end else if (!soft_done) begin
        soft_cnt[c] <= soft_cnt[c] + 12'h1;
      end
    end

    always_ff @(posedge clock) begin
      if (sys_rst) begin
        cur_code[c] <= VOUT_RESET;
        high_side_on[c] <= 1'b0;
        osc_slow[c] <= 1'b0;
        bleed_on[c] <= 1'b0;
        channel_on[c] <= 1'b0;
        skip_active[c] <= 1'b0;
        soft_start_active[c] <= 1'b0;
      end else begin
        if (slew_tick && cur_code[c] < target[c]) begin
          cur_code[c] <= cur_code[c] + 7'h01;
        end else if (slew_tick && cur_code[c] > target[c]) begin
          cur_code[c] <= cur_code[c] - 7'h01;
        end
        high_side_on[c] <= next_hs;
        osc_slow[c] <= run & short_s[c];
        bleed_on[c] <= (next_st == CH_OFF) & bleed_allow[c];
        channel_on[c] <= next_st != CH_OFF;
        skip_active[c] <= (next_st == CH_SKIP_PULSE) | (next_st == CH_SKIP_HOLD);
        soft_start_active[c] <= next_st == CH_SOFT;
      end
    end
  end

  assign soft_ramp_one = soft_cnt[0][11:8];
  assign soft_ramp_two = soft_cnt[1][11:8];
  assign vout_code_one = cur_code[0];
  assign vout_code_two = cur_code[1];

  ////////////////////////////////////////////////////////////////////////////
  // Power-good with programmed delay on each change; cleared at once when both enables are low
  wire any_on = en_s[0] | en_s[1];
  wire pg_target = any_on & (~en_s[0] | window_s[0]) & (~en_s[1] | window_s[1]);
  logic [17:0] pg_cnt;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pg_state <= 1'b0;
      pg_cnt <= 18'h0;
    end else if (!any_on) begin
      pg_state <= 1'b0;
      pg_cnt <= 18'h0;
    end else if (pg_target == pg_state) begin
      pg_cnt <= 18'h0;
    end else if (pg_cnt >= pg_delay(pg_sel, PG_DELAY_UNIT_CYCLES) - 18'h1) begin
      pg_state <= pg_target;
      pg_cnt <= 18'h0;
    end else begin
      pg_cnt <= pg_cnt + 18'h1;
    end
  end

  assign buck_power_good_out_o = 1'b0;
  assign buck_power_good_out_oe = ~pg_state;
endmodule
`default_nettype wire

// *** verification/dual_buck_control_i2c_assertions.sv ***
// Port-level assertions for the dual buck controller
`default_nettype none
module dual_buck_control_i2c_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Inputs
  input wire logic [1:0] buck_enable,
  input wire logic [1:0] ilim_reached,
  input wire logic [1:0] short_detect,
  input wire logic [1:0] dropout,
  input wire logic supply_above_fall,
  input wire logic thermal_hot,
  // Outputs
  input wire logic [1:0] high_side_on,
  input wire logic [1:0] osc_slow,
  input wire logic [1:0] channel_on,
  input wire logic [1:0] soft_start_active,
  input wire logic [6:0] vout_code_one,
  input wire logic buck_power_good_out_oe
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // Four cycles cover two sync flops plus the output flop
  pg_both_off_a: assert property ((buck_enable == 2'h0)[*4] |-> buck_power_good_out_oe)
    else $error("power good released with both off");
  ilim_cut_a: assert property (ilim_reached[0][*4] |-> !high_side_on[0])
    else $error("switch on at current limit");
  full_duty_a: assert property ((dropout[0] && !ilim_reached[0] && channel_on[0])[*4]
    |-> high_side_on[0]) else $error("switch not held on in dropout");
  short_slow_a: assert property ((short_detect[0] && channel_on[0])[*4] |-> osc_slow[0])
    else $error("oscillator not slowed on short");
  hot_off_a: assert property (thermal_hot[*5] |-> channel_on == 2'h0)
    else $error("channel on while hot");
  uv_off_a: assert property ((!supply_above_fall)[*5] |-> channel_on == 2'h0)
    else $error("channel on under lockout");
  soft_first_a: assert property ($rose(channel_on[0]) |-> soft_start_active[0])
    else $error("start without soft start");
  slew_step_a: assert property ($changed(vout_code_one) && !$past(sys_rst)
    |-> 7'(vout_code_one - $past(vout_code_one)) inside {7'h01, 7'h7F})
    else $error("code moved more than one step");
  cover property ($fell(buck_power_good_out_oe));
  cover property ($rose(soft_start_active[0]));
  cover property ($fell(channel_on[0]));
endmodule
bind dual_buck_control_i2c dual_buck_control_i2c_assertions i_dual_buck_control_i2c_assertions (
  .clock, .sys_rst, .buck_enable, .ilim_reached, .short_detect, .dropout,
  .supply_above_fall, .thermal_hot, .high_side_on, .osc_slow, .channel_on,
  .soft_start_active, .vout_code_one, .buck_power_good_out_oe);
`default_nettype wire

// *** verification/i2c_host_model.sv ***
// Bus master model standing in for the host controller
`default_nettype none
module i2c_host_model (
  // Clock and wire level
  input wire logic clock,
  input wire logic sda,
  // Driven pins, data as a pull-down
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Two clocks a quarter bit, so the bus clock period is 800 ns
  task automatic q(input logic c, input logic d);
    repeat (2) @(posedge clock);
    scl <= c;
    sda_low <= !d;
  endtask
  task automatic start;
    q(scl, 1'b1);
    q(1'b1, 1'b1);
    q(1'b1, 1'b0);
    q(1'b0, 1'b0);
  endtask
  task automatic stop;
    q(1'b0, 1'b0);
    q(1'b1, 1'b0);
    q(1'b1, 1'b1);
  endtask
  // Data moves only while clock is low; read mid-way through the high phase
  task automatic xfer(input logic [8:0] t, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      q(1'b0, t[i]);
      q(1'b1, t[i]);
      q(1'b1, t[i]);
      r[i] = sda;
      q(1'b0, t[i]);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
    output logic nak);
    logic [8:0] r0, r1, r2;
    start();
    xfer({a, 1'b0, 1'b1}, r0);
    xfer({p, 1'b1}, r1);
    xfer({d, 1'b1}, r2);
    stop();
    nak = r0[0] | r1[0] | r2[0];
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
    logic [8:0] r0, r1, r2, r3;
    start();
    xfer({a, 1'b0, 1'b1}, r0);
    xfer({p, 1'b1}, r1);
    start();
    xfer({a, 1'b1, 1'b1}, r2);
    // Master NACK closes the read
    xfer(9'h1FF, r3);
    stop();
    d = r3[8:1];
  endtask
endmodule
`default_nettype wire

// *** verification/dual_buck_control_i2c_tb.sv ***
// Self-checking bench for the dual buck controller
`default_nettype none
module dual_buck_control_i2c_tb
  import buck_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic pwm_clk_in = 1'b0;
  logic [1:0] pwm_div = 2'h0;
  logic [1:0] buck_enable = 2'h0, zero_cross = 2'h0, peak_trip = 2'h0, ilim_reached = 2'h0;
  logic [1:0] skip_trip = 2'h0, over_upper = 2'h0, at_nominal_low = 2'h0, under_lower = 2'h0;
  logic [1:0] short_detect = 2'h0, dropout = 2'h0, pg_window = 2'h0;
  logic [6:0] fuse_code_one = 7'h10, fuse_code_two = 7'h10;
  logic supply_above_rise = 1'b1, supply_above_fall = 1'b1;
  logic thermal_hot = 1'b0, thermal_cool = 1'b1;
  wire serial_clock_pin, sda_low, serial_data_pin_oe, buck_power_good_out_oe;
  wire [1:0] high_side_on, osc_slow, bleed_on, channel_on, skip_active, soft_start_active;
  wire [6:0] vout_code_one, vout_code_two;
  // Open-drain data line with pull-up
  wire sda_wire = !(sda_low || serial_data_pin_oe);
  int miscompares = 0;
  int cmp_count = 0;
  dual_buck_control_i2c #(.PG_DELAY_UNIT_CYCLES(20)) i_dual_buck_control_i2c (
    .clock, .sys_rst, .serial_clock_pin, .serial_data_pin_in(sda_wire),
    .serial_data_pin_out(), .serial_data_pin_oe, .pwm_clk_in, .buck_enable,
    .fuse_code_one, .fuse_code_two, .zero_cross, .peak_trip, .ilim_reached, .skip_trip,
    .over_upper, .at_nominal_low, .under_lower, .short_detect, .dropout, .pg_window,
    .supply_above_rise, .supply_above_fall, .thermal_hot, .thermal_cool, .high_side_on,
    .osc_slow, .bleed_on, .channel_on, .skip_active, .soft_start_active, .soft_ramp_one(),
    .soft_ramp_two(), .vout_code_one, .vout_code_two, .buck_power_good_out_o(),
    .buck_power_good_out_oe);
  i2c_host_model i_i2c_host_model (.clock, .sda(sda_wire), .scl(serial_clock_pin), .sda_low);
  always #50 clock = !clock;
  // PWM oscillator at a quarter of the system clock
  always @(posedge clock) begin
    pwm_div <= pwm_div + 2'h1;
    pwm_clk_in <= pwm_div[1];
  end
  ////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g, input string n);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic nak;
    i_i2c_host_model.wr(SLAVE_ADDR, p, d, nak);
    chk(8'h00, 8'(nak), "ack");
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    i_i2c_host_model.rd(SLAVE_ADDR, p, d);
    chk(e, d, "read");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic nak;
    chk(8'(VOUT_RESET), 8'(vout_code_one), "vout");
    rd(REG_BUCK_OPT, BUCK_OPT_RESET);
    rd(REG_SYS_OPT, SYS_OPT_RESET);
    wr(REG_VOUT_ONE, 8'h13);
    wr(REG_VOUT_TWO, 8'h0E);
    i_i2c_host_model.wr(7'h69, REG_VOUT_ONE, 8'h55, nak);
    chk(8'h01, 8'(nak), "foreign nak");
    rd(REG_VOUT_ONE, 8'h13);
    cyc(80);
    chk(8'(VOUT_RESET), 8'(vout_code_one), "fused");
    wr(REG_SYS_OPT, 8'h40);
    cyc(80);
    chk(8'h13, 8'(vout_code_one), "slew one");
    chk(8'h0E, 8'(vout_code_two), "slew two");
    $display("registers done");
  endtask
  task automatic t_power;
    buck_enable <= 2'h1;
    cyc(8);
    chk(8'h01, 8'(soft_start_active), "soft");
    chk(8'h02, 8'(bleed_on), "bleed");
    cyc(SOFT_START_CYCLES + 40);
    chk(8'h00, 8'(soft_start_active), "soft end");
    dropout <= 2'h1;
    peak_trip <= 2'h1;
    cyc(8);
    chk(8'h01, 8'(high_side_on), "full duty");
    ilim_reached <= 2'h1;
    cyc(8);
    chk(8'h00, 8'(high_side_on), "limit");
    dropout <= 2'h0;
    peak_trip <= 2'h0;
    ilim_reached <= 2'h0;
    short_detect <= 2'h1;
    cyc(8);
    chk(8'h01, 8'(osc_slow), "slow osc");
    short_detect <= 2'h0;
    $display("power done");
  endtask
  task automatic t_skip;
    zero_cross <= 2'h1;
    cyc(80);
    chk(8'h00, 8'(skip_active), "skip off");
    zero_cross <= 2'h0;
    wr(REG_BUCK_OPT, 8'h0D);
    zero_cross <= 2'h1;
    cyc(48);
    zero_cross <= 2'h0;
    cyc(12);
    zero_cross <= 2'h1;
    cyc(56);
    chk(8'h00, 8'(skip_active), "cleared");
    cyc(24);
    chk(8'h01, 8'(skip_active), "skip");
    zero_cross <= 2'h0;
    over_upper <= 2'h1;
    cyc(8);
    chk(8'h00, 8'(high_side_on), "hold");
    over_upper <= 2'h0;
    at_nominal_low <= 2'h1;
    cyc(8);
    chk(8'h01, 8'(high_side_on), "pulse");
    under_lower <= 2'h1;
    at_nominal_low <= 2'h0;
    cyc(8);
    chk(8'h00, 8'(skip_active), "skip exit");
    under_lower <= 2'h0;
    $display("skip done");
  endtask
  task automatic t_pg;
    pg_window <= 2'h1;
    cyc(10);
    chk(8'h01, 8'(buck_power_good_out_oe), "pg wait");
    cyc(30);
    chk(8'h00, 8'(buck_power_good_out_oe), "pg one");
    buck_enable <= 2'h3;
    cyc(40);
    chk(8'h01, 8'(buck_power_good_out_oe), "pg bad");
    pg_window <= 2'h3;
    cyc(40);
    chk(8'h00, 8'(buck_power_good_out_oe), "pg both");
    buck_enable <= 2'h0;
    cyc(5);
    chk(8'h01, 8'(buck_power_good_out_oe), "pg off");
    $display("power good done");
  endtask
  task automatic t_prot;
    wr(REG_BUCK_OPT, 8'h09);
    cyc(8);
    chk(8'h02, 8'(bleed_on), "bleed cut");
    buck_enable <= 2'h1;
    thermal_hot <= 1'b1;
    thermal_cool <= 1'b0;
    cyc(8);
    chk(8'h00, 8'(channel_on), "hot");
    thermal_hot <= 1'b0;
    thermal_cool <= 1'b1;
    cyc(8);
    chk(8'h01, 8'(soft_start_active), "cooled");
    supply_above_rise <= 1'b0;
    supply_above_fall <= 1'b0;
    cyc(8);
    chk(8'h00, 8'(channel_on), "uv");
    supply_above_fall <= 1'b1;
    cyc(8);
    chk(8'h00, 8'(channel_on), "uv held");
    supply_above_rise <= 1'b1;
    cyc(8);
    chk(8'h01, 8'(soft_start_active), "uv gone");
    $display("protection done");
  endtask
  initial begin
    cyc(12);
    sys_rst <= 1'b0;
    cyc(3);
    t_regs();
    t_power();
    t_skip();
    t_pg();
    t_prot();
    test_done();
  end
  // Tests need about 6000 clocks
  initial begin
    cyc(20000);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
